// ==== rtl/lsw_pkg.sv ====
package lsw_pkg;

   // Bus and field widths
   localparam int LSW_AW = 8;
   localparam int LSW_DW = 32;
   localparam int LSW_IW = 6;
   localparam int LSW_BW = 8;
   localparam int LSW_WW = 10;
   localparam int LSW_HI_FIELD_W = 4;
   localparam int LSW_HI_BITS = 2;
   localparam int LSW_IDX_LSB = 2;

   // Register indices; byte address is four times the index
   localparam logic [5:0] LSW_IDX_MODE = 6'h10;
   localparam logic [5:0] LSW_IDX_OUT_CFG = 6'h18;
   localparam logic [5:0] LSW_IDX_HSA_LO = 6'h2c;
   localparam logic [5:0] LSW_IDX_HSA_HI = 6'h2d;
   localparam logic [5:0] LSW_IDX_HSB_LO = 6'h2e;
   localparam logic [5:0] LSW_IDX_HSB_HI = 6'h2f;
   localparam logic [5:0] LSW_IDX_VSA_LO = 6'h30;
   localparam logic [5:0] LSW_IDX_VSA_HI = 6'h31;
   localparam logic [5:0] LSW_IDX_STATUS = 6'h3f;

   // Field positions
   localparam int LSW_MODE_LSB = 5;
   localparam int LSW_MODE_MSB = 6;
   localparam int LSW_SINGLE_BIT = 4;

   // Input channel mode codes
   localparam logic [1:0] LSW_MODE_DUAL0 = 2'h0;
   localparam logic [1:0] LSW_MODE_DUAL1 = 2'h1;
   localparam logic [1:0] LSW_MODE_INDEP = 2'h2;

   // Reset values
   localparam logic [7:0] LSW_RST_BYTE = 8'h00;
   localparam logic [3:0] LSW_RST_NIB = 4'h0;
   localparam logic [1:0] LSW_RST_MODE = 2'h0;
   localparam logic [9:0] LSW_WIDTH_ONE = 10'h001;
   localparam logic [9:0] LSW_WIDTH_ZERO = 10'h000;

   // How the channel B sync outputs are sourced
   typedef enum logic [1:0] {
      LSW_ROUTE_SINGLE,
      LSW_ROUTE_MIRROR,
      LSW_ROUTE_INDEP,
      LSW_ROUTE_OFF
   } lsw_route_t;

   // The three pulse widths in use
   typedef struct packed {
      logic [9:0] hs_a;
      logic [9:0] vs_a;
      logic [9:0] hs_b;
   } lsw_widths_t;

endpackage

// ==== rtl/lsw_pulse.sv ====
`timescale 1ns/1ps
module lsw_pulse
   import lsw_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic i_tick,
   input wire logic [LSW_WW-1:0] i_width,
   output logic o_pulse
);

   logic [LSW_WW-1:0] cnt;
   logic [LSW_WW-1:0] seen;
   logic [LSW_WW-1:0] lat_w;

   ////////////////////////////////////////////////////////////////////
   // Pulse rises on start, falls after width ticks; a zero width
   // gives no pulse at all. A new start restarts the count.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pulse <= 1'b0;
         cnt <= LSW_WIDTH_ZERO;
      end
      else if (i_start)
      begin
         o_pulse <= (i_width != LSW_WIDTH_ZERO);
         cnt <= i_width;
      end
      else if (o_pulse && i_tick)
      begin
         if (cnt == LSW_WIDTH_ONE)
            o_pulse <= 1'b0;
         cnt <= cnt - LSW_WIDTH_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checking aid: ticks seen while high, against the width taken
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         seen <= LSW_WIDTH_ZERO;
         lat_w <= LSW_WIDTH_ZERO;
      end
      else if (i_start)
      begin
         seen <= LSW_WIDTH_ZERO;
         lat_w <= i_width;
      end
      else if (o_pulse && i_tick)
         seen <= seen + LSW_WIDTH_ONE;
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_pulse_exact_len: assert property (
      $fell(o_pulse) && !$past(i_start) |-> seen == lat_w)
      else $error("sync pulse length differs from programmed width");

   a_pulse_zero_none: assert property (
      i_start && i_width == LSW_WIDTH_ZERO |=> !o_pulse)
      else $error("zero width still produced a pulse");

endmodule // lsw_pulse

// ==== rtl/lsw_sync_width.sv ====
`timescale 1ns/1ps
module lsw_sync_width
   import lsw_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [LSW_AW-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [LSW_DW-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [LSW_DW-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_line_start_a,
   input wire logic i_frame_start_a,
   input wire logic i_line_start_b,
   input wire logic i_frame_start_b,
   output logic o_hsync_a,
   output logic o_vsync_a,
   output logic o_hsync_b,
   output logic o_vsync_b
);

   logic [LSW_IW-1:0] idx;
   logic req;
   logic wr_fire;
   logic rd_fire;
   logic wr_byte;
   logic [1:0] chan_mode;
   logic single_out;
   lsw_route_t route;
   lsw_widths_t widths;
   logic [LSW_BW-1:0] hsa_lo;
   logic [LSW_HI_FIELD_W-1:0] hsa_hi;
   logic [LSW_BW-1:0] hsb_lo;
   logic [LSW_HI_FIELD_W-1:0] hsb_hi;
   logic [LSW_BW-1:0] vsa_lo;
   logic [LSW_HI_FIELD_W-1:0] vsa_hi;
   logic hs_a_p;
   logic vs_a_p;
   logic hs_b_p;
   logic hs_b_start;
   logic [LSW_DW-1:0] next_readdata;

   ////////////////////////////////////////////////////////////////////
   // Bus decode; the two low address bits are ignored
   assign idx = i_avs_address[LSW_AW-1:LSW_IDX_LSB];
   assign req = i_avs_read || i_avs_write;
   // A request fires at the edge where waitrequest is seen low
   assign wr_fire = i_avs_write && !o_avs_waitrequest;
   assign rd_fire = i_avs_read && !o_avs_waitrequest;
   // Registers are one byte wide and live in lane 0 only
   assign wr_byte = wr_fire && i_avs_byteenable[0];

   ////////////////////////////////////////////////////////////////////
   // Waitrequest: high while idle, low for one cycle per request.
   // One fixed wait state keeps read data a clean flop output.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_avs_waitrequest <= 1'b1;
      else if (req && o_avs_waitrequest)
         o_avs_waitrequest <= 1'b0;
      else
         o_avs_waitrequest <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // Mode and output configuration; only the bits this block uses
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         chan_mode <= LSW_RST_MODE;
         single_out <= 1'b0;
      end
      else if (wr_byte && idx == LSW_IDX_MODE)
         chan_mode <= i_avs_writedata[LSW_MODE_MSB:LSW_MODE_LSB];
      else if (wr_byte && idx == LSW_IDX_OUT_CFG)
         single_out <= i_avs_writedata[LSW_SINGLE_BIT];
   end

   ////////////////////////////////////////////////////////////////////
   // Width register pairs
   lsw_width_reg #(
      .LO_IDX(LSW_IDX_HSA_LO),
      .HI_IDX(LSW_IDX_HSA_HI)
   ) u_hsa_reg (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_wr(wr_byte),
      .i_idx(idx),
      .i_wdata(i_avs_writedata[LSW_BW-1:0]),
      .o_lo(hsa_lo),
      .o_hi(hsa_hi),
      .o_width(widths.hs_a)
   );

   lsw_width_reg #(
      .LO_IDX(LSW_IDX_HSB_LO),
      .HI_IDX(LSW_IDX_HSB_HI)
   ) u_hsb_reg (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_wr(wr_byte),
      .i_idx(idx),
      .i_wdata(i_avs_writedata[LSW_BW-1:0]),
      .o_lo(hsb_lo),
      .o_hi(hsb_hi),
      .o_width(widths.hs_b)
   );

   lsw_width_reg #(
      .LO_IDX(LSW_IDX_VSA_LO),
      .HI_IDX(LSW_IDX_VSA_HI)
   ) u_vsa_reg (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_wr(wr_byte),
      .i_idx(idx),
      .i_wdata(i_avs_writedata[LSW_BW-1:0]),
      .o_lo(vsa_lo),
      .o_hi(vsa_hi),
      .o_width(widths.vs_a)
   );

   ////////////////////////////////////////////////////////////////////
   // Route selection; mode 11 in dual output leaves channel B quiet
   always_comb
   begin
      if (single_out)
         route = LSW_ROUTE_SINGLE;
      else if (chan_mode == LSW_MODE_INDEP)
         route = LSW_ROUTE_INDEP;
      else if (chan_mode == LSW_MODE_DUAL0 ||
               chan_mode == LSW_MODE_DUAL1)
         route = LSW_ROUTE_MIRROR;
      else
         route = LSW_ROUTE_OFF;
   end

   ////////////////////////////////////////////////////////////////////
   // Pulse generators. Triggers come from timing logic on this clock,
   // so they are used without synchronisers.
   lsw_pulse u_hs_a (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_start(i_line_start_a),
      .i_tick(1'b1),
      .i_width(widths.hs_a),
      .o_pulse(hs_a_p)
   );

   // Vertical width counts line starts, not pixel clocks
   lsw_pulse u_vs_a (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_start(i_frame_start_a),
      .i_tick(i_line_start_a),
      .i_width(widths.vs_a),
      .o_pulse(vs_a_p)
   );

   // Channel B widths only ever start a pulse in independent mode
   assign hs_b_start = i_line_start_b && route == LSW_ROUTE_INDEP;

   lsw_pulse u_hs_b (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_start(hs_b_start),
      .i_tick(1'b1),
      .i_width(widths.hs_b),
      .o_pulse(hs_b_p)
   );

   ////////////////////////////////////////////////////////////////////
   // Channel A outputs, one flop after the generators
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_hsync_a <= 1'b0;
         o_vsync_a <= 1'b0;
      end
      else
      begin
         o_hsync_a <= hs_a_p;
         o_vsync_a <= vs_a_p;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Channel B outputs. Mirror copies A; in independent mode the
   // vertical width of B lives elsewhere, so vsync B stays low here
   // and the B frame trigger is unused.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_hsync_b <= 1'b0;
         o_vsync_b <= 1'b0;
      end
      else
      begin
         case (route)
            LSW_ROUTE_MIRROR:
            begin
               o_hsync_b <= hs_a_p;
               o_vsync_b <= vs_a_p;
            end
            LSW_ROUTE_INDEP:
            begin
               o_hsync_b <= hs_b_p;
               o_vsync_b <= 1'b0;
            end
            default:
            begin
               o_hsync_b <= 1'b0;
               o_vsync_b <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux; reserved bits and unmapped indices read zero
   always_comb
   begin
      next_readdata = '0;
      case (idx)
         LSW_IDX_MODE:
            next_readdata[LSW_MODE_MSB:LSW_MODE_LSB] = chan_mode;
         LSW_IDX_OUT_CFG:
            next_readdata[LSW_SINGLE_BIT] = single_out;
         LSW_IDX_HSA_LO: next_readdata[LSW_BW-1:0] = hsa_lo;
         LSW_IDX_HSA_HI:
            next_readdata[LSW_HI_FIELD_W-1:0] = hsa_hi;
         LSW_IDX_HSB_LO: next_readdata[LSW_BW-1:0] = hsb_lo;
         LSW_IDX_HSB_HI:
            next_readdata[LSW_HI_FIELD_W-1:0] = hsb_hi;
         LSW_IDX_VSA_LO: next_readdata[LSW_BW-1:0] = vsa_lo;
         LSW_IDX_VSA_HI:
            next_readdata[LSW_HI_FIELD_W-1:0] = vsa_hi;
         LSW_IDX_STATUS:
            next_readdata[5:0] = {o_vsync_b, o_hsync_b, o_vsync_a,
                                  o_hsync_a, route};
         default: next_readdata = '0;
      endcase
   end

   // Captured in the wait cycle so data stand when waitrequest drops
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_avs_readdata <= '0;
      else if (i_avs_read && o_avs_waitrequest)
         o_avs_readdata <= next_readdata;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_bus_one_wait: assert property (
      req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
      o_avs_waitrequest)
      else $error("bus answer not given after one wait cycle");

   a_hsa_low_write: assert property (
      wr_byte && idx == LSW_IDX_HSA_LO |=>
      widths.hs_a[LSW_BW-1:0] == $past(i_avs_writedata[LSW_BW-1:0]))
      else $error("channel A hsync low byte not stored");

   a_hsa_high_write: assert property (
      wr_byte && idx == LSW_IDX_HSA_HI |=>
      widths.hs_a[LSW_WW-1:LSW_BW] ==
      $past(i_avs_writedata[LSW_HI_BITS-1:0]))
      else $error("channel A hsync high bits not stored");

   a_mirror_route: assert property (
      route == LSW_ROUTE_MIRROR |=>
      o_hsync_b == $past(hs_a_p) && o_vsync_b == $past(vs_a_p))
      else $error("channel B does not follow channel A");

   a_single_b_low: assert property (
      route == LSW_ROUTE_SINGLE |=> !o_hsync_b && !o_vsync_b)
      else $error("channel B active in single output mode");

   a_hsb_low_write: assert property (
      wr_byte && idx == LSW_IDX_HSB_LO |=>
      widths.hs_b[LSW_BW-1:0] == $past(i_avs_writedata[LSW_BW-1:0]))
      else $error("channel B hsync low byte not stored");

   a_hsb_high_read: assert property (
      rd_fire && idx == LSW_IDX_HSB_HI |->
      o_avs_readdata[LSW_DW-1:LSW_HI_FIELD_W] == '0 &&
      o_avs_readdata[LSW_HI_FIELD_W-1:0] == hsb_hi)
      else $error("channel B hsync high readback wrong");

   a_hsb_mode_gate: assert property (
      $rose(hs_b_p) |-> $past(route) == LSW_ROUTE_INDEP)
      else $error("channel B width used outside mode 10");

   a_vsa_write: assert property (
      wr_byte && idx == LSW_IDX_VSA_LO |=>
      widths.vs_a[LSW_BW-1:0] == $past(i_avs_writedata[LSW_BW-1:0]))
      else $error("channel A vsync low byte not stored");

   a_vsa_high_write: assert property (
      wr_byte && idx == LSW_IDX_VSA_HI |=>
      widths.vs_a[LSW_WW-1:LSW_BW] ==
      $past(i_avs_writedata[LSW_HI_BITS-1:0]))
      else $error("channel A vsync high bits not stored");

   a_indep_b_follow: assert property (
      route == LSW_ROUTE_INDEP && hs_b_p |=> o_hsync_b)
      else $error("independent channel B hsync not driven");

   // A retrigger inside the pulse is legal, so quiet lines are required
   a_hsync_len_two: assert property (
      i_line_start_a && widths.hs_a == 10'h002 ##1 (!i_line_start_a) [*2]
      |-> $past(hs_a_p) && hs_a_p ##1 !hs_a_p)
      else $error("hsync width of two not held two clocks");

   c_mirror_pulse: cover property (
      route == LSW_ROUTE_MIRROR && $rose(o_hsync_b));
   c_indep_pulse: cover property (
      route == LSW_ROUTE_INDEP && $rose(o_hsync_b));
   c_vsync_a_fall: cover property ($fell(o_vsync_a));
   c_read_status: cover property (rd_fire && idx == LSW_IDX_STATUS);

endmodule // lsw_sync_width

// ==== rtl/lsw_width_reg.sv ====
`timescale 1ns/1ps
module lsw_width_reg
   import lsw_pkg::*;
#(
   parameter logic [5:0] LO_IDX = 6'h00,
   parameter logic [5:0] HI_IDX = 6'h01
)
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic [LSW_IW-1:0] i_idx,
   input wire logic [LSW_BW-1:0] i_wdata,
   output logic [LSW_BW-1:0] o_lo,
   output logic [LSW_HI_FIELD_W-1:0] o_hi,
   output logic [LSW_WW-1:0] o_width
);

   ////////////////////////////////////////////////////////////////////
   // Low byte and high nibble, written one byte at a time
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_lo <= LSW_RST_BYTE;
         o_hi <= LSW_RST_NIB;
      end
      else if (i_wr && i_idx == LO_IDX)
         o_lo <= i_wdata;
      else if (i_wr && i_idx == HI_IDX)
         o_hi <= i_wdata[LSW_HI_FIELD_W-1:0];
   end

   // Only two bits of the nibble reach the width; the rest reads back
   assign o_width = {o_hi[LSW_HI_BITS-1:0], o_lo};

endmodule // lsw_width_reg

// ==== verif/lsw_panel_model.sv ====
`timescale 1ns/1ps
// Panel side: measures how long one active high sync pulse stands
module lsw_pulse_meter
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_sig,
   output logic [10:0] o_last,
   output logic [7:0] o_count
);
   logic prev;
   logic [10:0] run;

   // Width is latched only on the fall, so a cut pulse never reports
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         prev <= 1'b0;
         run <= 11'h000;
         o_last <= 11'h000;
         o_count <= 8'h00;
      end
      else
      begin
         prev <= i_sig;
         if (i_sig)
            run <= run + 11'h001;
         else if (prev)
         begin
            o_last <= run;
            o_count <= o_count + 8'h01;
            run <= 11'h000;
         end
      end
   end
endmodule // lsw_pulse_meter

////////////////////////////////////////////////////////////////////////
// Receiving panel: takes the four syncs and reports what it saw
module lsw_panel_model
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hsync_a,
   input wire logic i_vsync_a,
   input wire logic i_hsync_b,
   input wire logic i_vsync_b,
   output logic [10:0] o_hs_a_w,
   output logic [10:0] o_hs_b_w,
   output logic [7:0] o_hs_b_n,
   output logic [10:0] o_vs_a_w,
   output logic [10:0] o_vs_b_w,
   output logic [9:0] o_vs_a_lines
);
   logic hs_prev;
   logic vs_prev;
   logic [9:0] lines;

   lsw_pulse_meter hs_a_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_sig(i_hsync_a), .o_last(o_hs_a_w), .o_count());
   lsw_pulse_meter hs_b_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_sig(i_hsync_b), .o_last(o_hs_b_w), .o_count(o_hs_b_n));
   lsw_pulse_meter vs_a_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_sig(i_vsync_a), .o_last(o_vs_a_w), .o_count());
   lsw_pulse_meter vs_b_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_sig(i_vsync_b), .o_last(o_vs_b_w), .o_count());

   // A panel counts vsync in lines: hsync starts seen while vsync is up
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         hs_prev <= 1'b0;
         vs_prev <= 1'b0;
         lines <= 10'h000;
         o_vs_a_lines <= 10'h000;
      end
      else
      begin
         hs_prev <= i_hsync_a;
         vs_prev <= i_vsync_a;
         if (i_vsync_a && i_hsync_a && !hs_prev)
            lines <= lines + 10'h001;
         else if (!i_vsync_a && vs_prev)
         begin
            o_vs_a_lines <= lines;
            lines <= 10'h000;
         end
      end
   end
endmodule // lsw_panel_model

// ==== verif/lsw_sync_width_tb.sv ====
`timescale 1ns/1ps
module lsw_sync_width_tb;
   import lsw_pkg::*;

   typedef struct packed {
      logic single;
      logic [1:0] mode;
      logic [7:0] a_lo;
      logic [3:0] a_hi;
      logic [7:0] b_lo;
      logic [3:0] b_hi;
      logic b_on;
      logic b_own;
   } lsw_row_t;

   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0] i_avs_byteenable = 4'h0;
   logic i_line_start_a = 1'b0;
   logic i_frame_start_a = 1'b0;
   logic i_line_start_b = 1'b0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic o_hsync_a, o_vsync_a, o_hsync_b, o_vsync_b;
   logic [10:0] hs_a_w, hs_b_w, vs_a_w, vs_b_w;
   logic [7:0] hs_b_n, nb;
   logic [9:0] vs_a_lines, wa, wb;
   logic [31:0] rd;
   logic [31:0] rt;
   lsw_row_t r;
   int err_total = 0;
   int total_checks = 0;
   int wait_n;
   // Single, mode, A low/high, B low/high, B pulses, B own width
   lsw_row_t rows [6] = '{
      '{1'b1, 2'h0, 8'h05, 4'h0, 8'h03, 4'h0, 1'b0, 1'b0},
      '{1'b0, 2'h0, 8'h02, 4'h1, 8'h07, 4'h0, 1'b1, 1'b0},
      '{1'b0, 2'h1, 8'h01, 4'he, 8'h09, 4'h0, 1'b1, 1'b0},
      '{1'b0, 2'h2, 8'h04, 4'h0, 8'hff, 4'h6, 1'b1, 1'b1},
      '{1'b0, 2'h3, 8'h03, 4'h0, 8'h05, 4'h0, 1'b0, 1'b0},
      '{1'b1, 2'h2, 8'h06, 4'h0, 8'h05, 4'h0, 1'b0, 1'b0}};

   always #25 i_ref_clk = ~i_ref_clk;

   lsw_sync_width dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest),
      .i_line_start_a(i_line_start_a), .i_frame_start_a(i_frame_start_a),
      .i_line_start_b(i_line_start_b), .i_frame_start_b(1'b0),
      .o_hsync_a(o_hsync_a), .o_vsync_a(o_vsync_a),
      .o_hsync_b(o_hsync_b), .o_vsync_b(o_vsync_b));

   lsw_panel_model panel_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_hsync_a(o_hsync_a), .i_vsync_a(o_vsync_a),
      .i_hsync_b(o_hsync_b), .i_vsync_b(o_vsync_b),
      .o_hs_a_w(hs_a_w), .o_hs_b_w(hs_b_w), .o_hs_b_n(hs_b_n),
      .o_vs_a_w(vs_a_w), .o_vs_b_w(vs_b_w), .o_vs_a_lines(vs_a_lines));

   ////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, exp, input string msg);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask

   function automatic logic [7:0] ad(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction

   // Bounded wait for the edge that samples waitrequest low
   task automatic wait_ack();
      int n;
      n = 0;
      do
      begin
         @(posedge i_ref_clk);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
         check(32'h1, 32'h0, "bus never answered");
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] be = 4'hf);
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      i_avs_write <= 1'b1;
      wait_ack();
      i_avs_write <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_read <= 1'b1;
      wait_ack();
      d = o_avs_readdata;
      i_avs_read <= 1'b0;
   endtask

   // One cycle trigger pulses, then all triggers low again
   task automatic trig(input logic a, b, f);
      @(posedge i_ref_clk);
      i_line_start_a <= a;
      i_line_start_b <= b;
      i_frame_start_a <= f;
      @(posedge i_ref_clk);
      i_line_start_a <= 1'b0;
      i_line_start_b <= 1'b0;
      i_frame_start_a <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 3700 cycles of tests
   initial
   begin
      repeat (40000) @(posedge i_ref_clk);
      err_total++;
      finish_test();
   end

   initial
   begin
      repeat (8) @(posedge i_ref_clk);
      check(32'({o_hsync_a, o_hsync_b, o_vsync_b, o_avs_waitrequest}),
            32'h1, "outputs in reset");
      i_resetn <= 1'b1;
      // Width registers: reset value, all ones back, reserved nibble 0
      for (int i = 0; i < 6; i++)
      begin
         bus_rd(ad(LSW_IDX_HSA_LO + 6'(i)), rd);
         check(rd, 32'h0, "reset value");
         bus_wr(ad(LSW_IDX_HSA_LO + 6'(i)), 32'hffff_ffff);
         bus_rd(ad(LSW_IDX_HSA_LO + 6'(i)), rd);
         check(rd, (i % 2) ? 32'h0f : 32'hff, "readback");
      end
      bus_wr(ad(LSW_IDX_HSA_LO), 32'h0, 4'h0);
      bus_rd(ad(LSW_IDX_HSA_LO), rd);
      check(rd, 32'hff, "masked write");
      bus_wr(8'hc8, 32'hffff_ffff);
      bus_rd(8'hc8, rd);
      check(rd, 32'h0, "unmapped read");
      // Mode table: every channel mode with the single bit clear, modes 00 and 10 with it set
      foreach (rows[i])
      begin
         r = rows[i];
         bus_wr(ad(LSW_IDX_OUT_CFG), {27'h0, r.single, 4'h0});
         bus_wr(ad(LSW_IDX_MODE), {25'h0, r.mode, 5'h00});
         bus_wr(ad(LSW_IDX_HSA_LO), {24'h0, r.a_lo});
         bus_wr(ad(LSW_IDX_HSA_HI), {28'h0, r.a_hi});
         bus_wr(ad(LSW_IDX_HSB_LO), {24'h0, r.b_lo});
         bus_wr(ad(LSW_IDX_HSB_HI), {28'h0, r.b_hi});
         // Route code: single 0, mode 00/01 mirror 1, mode 10 and 11 as is
         rt = r.single ? 32'h0 : (r.mode[1] ? 32'(r.mode) : 32'h1);
         bus_rd(ad(LSW_IDX_STATUS), rd);
         check(rd, rt, "route status");
         nb = hs_b_n + {7'h0, r.b_on};
         wa = {r.a_hi[1:0], r.a_lo};
         wb = r.b_own ? {r.b_hi[1:0], r.b_lo} : wa;
         wait_n = wa + wb + 8;
         trig(1'b1, 1'b1, 1'b0);
         repeat (wait_n) @(posedge i_ref_clk);
         check(32'(hs_a_w), 32'(wa), "hsync a width");
         check(32'(hs_b_n), 32'(nb), "hsync b count");
         if (r.b_on)
            check(32'(hs_b_w), 32'(wb), "hsync b width");
      end
      // Retrigger two cycles into a six clock pulse restarts it
      trig(1'b1, 1'b0, 1'b0);
      trig(1'b1, 1'b0, 1'b0);
      repeat (16) @(posedge i_ref_clk);
      check(32'(hs_a_w), 32'h8, "retrigger width");
      // Vsync of 0x102 lines, mirrored onto channel B
      bus_wr(ad(LSW_IDX_OUT_CFG), 32'h0);
      bus_wr(ad(LSW_IDX_MODE), 32'h0);
      bus_wr(ad(LSW_IDX_HSA_LO), 32'h2);
      bus_wr(ad(LSW_IDX_HSA_HI), 32'h0);
      bus_wr(ad(LSW_IDX_VSA_LO), 32'h2);
      bus_wr(ad(LSW_IDX_VSA_HI), 32'h5);
      for (int i = 0; i < 262; i++)
      begin
         trig(1'b1, 1'b0, i == 0);
         repeat (2) @(posedge i_ref_clk);
      end
      check(32'(vs_a_lines), 32'h102, "vsync lines");
      // Lines come every four clocks, so 0x102 lines last 0x408 clocks
      check(32'(vs_a_w), 32'h408, "vsync a clocks");
      check(32'(vs_b_w), 32'(vs_a_w), "vsync b mirror");
      // Reset in mid pulse clears outputs and registers
      trig(1'b1, 1'b0, 1'b0);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      check(32'({o_hsync_a, o_hsync_b, o_vsync_a, o_avs_waitrequest}),
            32'h1, "outputs in reset");
      i_resetn <= 1'b1;
      bus_rd(ad(LSW_IDX_VSA_HI), rd);
      check(rd, 32'h0, "register after reset");
      finish_test();
   end
endmodule // lsw_sync_width_tb
